// ### bench/test_hibernate_rtc_match_wake.sv
`timescale 1ns/100ps
`default_nettype none
`include "hib_rtc_consts.svh"
module test_hibernate_rtc_match_wake;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, regulator_enable;
    logic        time_src, wake_pin_n, low_supply;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          fail_count, cmp_count;

    hib_rtc_top uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .time_src(time_src),
        .wake_pin_n(wake_pin_n), .low_supply(low_supply),
        .regulator_enable(regulator_enable)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Rollover alone needs about 131k cycles at four clocks per source period
    initial begin
        #3500000;
        fail_count++;
        report_and_stop();
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic wr_a(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        bready <= 1'b0;
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge aclk);
    endtask

    task automatic rd_a(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        rready <= 1'b0;
        rv = rdata;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge aclk);
    endtask

    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        wr_a({2'b00, i, 2'b00}, d, `RESP_OKAY);
    endtask

    task automatic rchk(input string what, input logic [3:0] i, input logic [31:0] exp);
        rd_a({2'b00, i, 2'b00}, `RESP_OKAY);
        chk(what, exp, rv);
    endtask

    // Each level held two clocks: the filter needs stages two and three to agree
    task automatic ticks(input int n);
        repeat (n) begin
            time_src <= 1'b1;
            repeat (2) @(posedge aclk);
            time_src <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        repeat (10) @(posedge aclk);
    endtask

    task automatic t_reset;
        chk("regulator", 32'h1, {31'h0, regulator_enable});
        rchk("trim", `REG_TRIM, 32'h7fff);
        rchk("wake", `REG_WAKE_CFG, 32'h0);
    endtask

    task automatic t_regs;
        wr(`REG_MATCH0, 32'hdead_beef);
        rchk("match0", `REG_MATCH0, 32'hdead_beef);
        wr(`REG_MATCH1, 32'h1357_9bdf);
        rchk("match1", `REG_MATCH1, 32'h1357_9bdf);
        wr(`REG_SUBSEC_MATCH0, 32'hffff_0003);
        rchk("ss match", `REG_SUBSEC_MATCH0, 32'h3);
        wr(`REG_TRIM, 32'h1234_8001);
        rchk("trim", `REG_TRIM, 32'h8001);
        for (int i = 0; i < 8; i++) begin
            wr(`REG_WAKE_CFG, 32'(i));
            rchk("wake", `REG_WAKE_CFG, 32'(i));
        end
        wr(`REG_SUBSEC, 32'h55);
        wr_a(8'h30, 32'h1, `RESP_SLVERR);
        rd_a(8'h30, `RESP_SLVERR);
        chk("unmapped", 32'h0, rv);
        wr(`REG_TRIM, 32'h7fff);
    endtask

    // Counter off: ticks and an equal match must do nothing
    task automatic t_disabled;
        wr(`REG_MATCH1, 32'h0);
        wr(`REG_STATUS_CLEAR, 32'hf);
        ticks(20);
        rchk("subsec", `REG_SUBSEC, 32'h0);
        rchk("seconds", `REG_SECONDS, 32'h0);
        rchk("raw", `REG_RAW_STATUS, 32'h0);
    endtask

    task automatic t_count;
        wr(`REG_CONTROL, 32'h1);
        wr(`REG_SECONDS, 32'd100);
        ticks(5);
        rchk("subsec", `REG_SUBSEC, 32'd5);
        rchk("seconds", `REG_SECONDS, 32'd100);
    endtask

    task automatic t_match0;
        wr(`REG_MATCH0, 32'd300);
        wr(`REG_SECONDS, 32'd300);
        wr(`REG_STATUS_CLEAR, 32'hf);
        ticks(2);
        rchk("raw", `REG_RAW_STATUS, 32'h0);
        ticks(1);
        rchk("raw", `REG_RAW_STATUS, 32'h4);
        rchk("masked", `REG_MASKED_STATUS, 32'h0);
        wr(`REG_IRQ_ENABLE, 32'h4);
        rchk("masked", `REG_MASKED_STATUS, 32'h4);
        wr(`REG_STATUS_CLEAR, 32'hf);
        rchk("raw", `REG_RAW_STATUS, 32'h0);
    endtask

    task automatic t_match1;
        wr(`REG_MATCH1, 32'd200);
        wr(`REG_SECONDS, 32'd200);
        rchk("raw", `REG_RAW_STATUS, 32'h8);
        wr(`REG_SECONDS, 32'd201);
        rchk("raw", `REG_RAW_STATUS, 32'h8);
        rchk("masked", `REG_MASKED_STATUS, 32'h0);
        wr(`REG_STATUS_CLEAR, 32'hf);
    endtask

    task automatic t_wake;
        wr(`REG_WAKE_CFG, 32'h0);
        wr(`REG_CONTROL, 32'h3);
        chk("regulator", 32'h0, {31'h0, regulator_enable});
        wake_pin_n <= 1'b0;
        ticks(0);
        chk("regulator", 32'h0, {31'h0, regulator_enable});
        wr(`REG_WAKE_CFG, 32'h1);
        ticks(0);
        chk("regulator", 32'h1, {31'h0, regulator_enable});
        wake_pin_n <= 1'b1;
        wr(`REG_WAKE_CFG, 32'h4);
        wr(`REG_CONTROL, 32'h3);
        chk("regulator", 32'h0, {31'h0, regulator_enable});
        low_supply <= 1'b1;
        ticks(0);
        chk("regulator", 32'h1, {31'h0, regulator_enable});
        low_supply <= 1'b0;
        rchk("raw", `REG_RAW_STATUS, 32'h3);
        wr(`REG_WAKE_CFG, 32'h2);
        wr(`REG_MATCH1, 32'd500);
        wr(`REG_CONTROL, 32'h3);
        chk("regulator", 32'h0, {31'h0, regulator_enable});
        wr(`REG_SECONDS, 32'd500);
        ticks(0);
        chk("regulator", 32'h1, {31'h0, regulator_enable});
    endtask

    task automatic t_roll;
        wr(`REG_SECONDS, 32'd5);
        ticks(32767);
        rchk("subsec", `REG_SUBSEC, 32'h7fff);
        ticks(1);
        rchk("subsec", `REG_SUBSEC, 32'h0);
        rchk("seconds", `REG_SECONDS, 32'd6);
    endtask

    task automatic t_trim;
        wr(`REG_TRIM, 32'h10);
        wr(`REG_SECONDS, 32'd63);
        ticks(16);
        rchk("seconds", `REG_SECONDS, 32'd63);
        ticks(1);
        rchk("seconds", `REG_SECONDS, 32'd64);
    endtask

    initial begin
        fail_count = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        time_src = 1'b0;
        wake_pin_n = 1'b1;
        low_supply = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_regs();
        t_disabled();
        t_count();
        t_match0();
        t_match1();
        t_wake();
        t_roll();
        t_trim();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### rtl/hib_rtc_consts.svh
`ifndef HIB_RTC_CONSTS_SVH
`define HIB_RTC_CONSTS_SVH

`define ADDR_W            8
`define REG_CONTROL       4'h0
`define REG_SECONDS       4'h1
`define REG_MATCH0        4'h2
`define REG_MATCH1        4'h3
`define REG_SUBSEC        4'h4
`define REG_SUBSEC_MATCH0 4'h5
`define REG_TRIM          4'h6
`define REG_WAKE_CFG      4'h7
`define REG_IRQ_ENABLE    4'h8
`define REG_RAW_STATUS    4'h9
`define REG_MASKED_STATUS 4'ha
`define REG_STATUS_CLEAR  4'hb

`define CTL_RTC_ENABLE    0
`define CTL_HIB_REQUEST   1

`define WAKE_PIN          0
`define WAKE_RTC          1
`define WAKE_LOW_SUPPLY   2

`define ST_PIN_WAKE       0
`define ST_LOW_SUPPLY     1
`define ST_MATCH0         2
`define ST_MATCH1         3

`define TRIM_RESET        16'h7fff
`define SUBSEC_TOP        16'h7fff
`define TRIM_SECOND       6'h3f

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ### rtl/hib_rtc_pkg.sv
package hib_rtc_pkg;
    typedef enum logic [0:0] {
        POWER_RUN = 1'b0,
        POWER_HIB = 1'b1
    } power_state_t;
endpackage

// ### rtl/hib_rtc_top.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "hib_rtc_consts.svh"
module hib_rtc_top
    import hib_rtc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        time_src,
    input  wire logic        wake_pin_n,
    input  wire logic        low_supply,
    output logic             regulator_enable
);
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        return (addr[7:6] == 2'b00) && (addr[5:2] <= `REG_STATUS_CLEAR);
    endfunction

    tick_if tk ();

    time_source_tick u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .time_src(time_src),
        .tk      (tk)
    );

    logic [7:0]   aw_addr_q;
    logic [31:0]  w_data_q;
    logic [3:0]   w_strb_q;
    logic [7:0]   ar_addr_q;
    logic         rtc_enable;
    logic [31:0]  seconds;
    logic [31:0]  match0;
    logic [31:0]  match1;
    logic [15:0]  subsec;
    logic [15:0]  subsec_match0;
    logic [15:0]  trim;
    logic [2:0]   wake_cfg;
    logic [3:0]   irq_enable;
    logic [3:0]   raw_status;
    logic         match0_prev;
    logic         match1_prev;
    logic [1:0]   pin_s1;
    logic [1:0]   pin_s2;
    logic [1:0]   pin_s3;
    logic [1:0]   pin_level;
    logic [1:0]   pin_prev;
    power_state_t power_state;
    power_state_t next_power_state;

    // Write happens once both address and data are held
    wire write_go = ~awready & ~wready & ~bvalid;
    wire w_ok     = mapped(aw_addr_q);
    wire [3:0] w_idx = aw_addr_q[5:2];
    wire w_ctl    = write_go & w_ok & (w_idx == `REG_CONTROL);
    wire w_sec    = write_go & w_ok & (w_idx == `REG_SECONDS);
    wire w_m0     = write_go & w_ok & (w_idx == `REG_MATCH0);
    wire w_m1     = write_go & w_ok & (w_idx == `REG_MATCH1);
    wire w_ssm0   = write_go & w_ok & (w_idx == `REG_SUBSEC_MATCH0);
    wire w_trim   = write_go & w_ok & (w_idx == `REG_TRIM);
    wire w_wake   = write_go & w_ok & (w_idx == `REG_WAKE_CFG);
    wire w_irqen  = write_go & w_ok & (w_idx == `REG_IRQ_ENABLE);
    wire w_clear  = write_go & w_ok & (w_idx == `REG_STATUS_CLEAR);
    wire [31:0] ctl_merged = merge({30'h0, 1'b0, rtc_enable}, w_data_q, w_strb_q);
    wire hib_request = w_ctl & ctl_merged[`CTL_HIB_REQUEST];
    wire [3:0] clear_mask = w_clear ? (w_data_q[3:0] & {4{w_strb_q[0]}}) : 4'h0;

    // Trim stands in for the nominal terminal count in one second of 64
    wire trim_second = (seconds[5:0] == `TRIM_SECOND);
    wire [15:0] sub_term = trim_second ? trim : `SUBSEC_TOP;
    wire step     = rtc_enable & tk.tick;
    wire sub_roll = step & (subsec >= sub_term);

    wire match0_eq = rtc_enable & (seconds == match0) & (subsec == subsec_match0);
    wire match1_eq = rtc_enable & (seconds == match1);
    wire match0_evt = match0_eq & ~match0_prev;
    wire match1_evt = match1_eq & ~match1_prev;
    wire pin_asserted = ~pin_level[0];
    wire low_level    = pin_level[1];
    wire pin_evt = pin_asserted & pin_prev[0];
    wire low_evt = low_level & ~pin_prev[1];
    wire [3:0] events = {match1_evt, match0_evt, low_evt, pin_evt};
    wire [3:0] masked_status = raw_status & irq_enable;

    wire wake_req = (wake_cfg[`WAKE_PIN] & pin_asserted)
                  | (wake_cfg[`WAKE_RTC] & rtc_enable & (match0_eq | match1_eq))
                  | (wake_cfg[`WAKE_LOW_SUPPLY] & low_level);

    wire [3:0] r_idx = ar_addr_q[5:2];
    wire r_ok = mapped(ar_addr_q);
    wire [31:0] rd_value =
        (r_idx == `REG_CONTROL)       ? {31'h0, rtc_enable} :
        (r_idx == `REG_SECONDS)       ? seconds :
        (r_idx == `REG_MATCH0)        ? match0 :
        (r_idx == `REG_MATCH1)        ? match1 :
        (r_idx == `REG_SUBSEC)        ? {16'h0, subsec} :
        (r_idx == `REG_SUBSEC_MATCH0) ? {16'h0, subsec_match0} :
        (r_idx == `REG_TRIM)          ? {16'h0, trim} :
        (r_idx == `REG_WAKE_CFG)      ? {29'h0, wake_cfg} :
        (r_idx == `REG_IRQ_ENABLE)    ? {28'h0, irq_enable} :
        (r_idx == `REG_RAW_STATUS)    ? {28'h0, raw_status} :
        (r_idx == `REG_MASKED_STATUS) ? {28'h0, masked_status} :
                                        32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready   <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (write_go) begin
                bvalid <= 1'b1;
                bresp  <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready   <= 1'b1;
            rvalid    <= 1'b0;
            rdata     <= 32'h0;
            rresp     <= `RESP_OKAY;
            ar_addr_q <= 8'h00;
        end else begin
            if (arvalid && arready) begin
                arready   <= 1'b0;
                ar_addr_q <= araddr;
            end
            if (!arready && !rvalid) begin
                rvalid <= 1'b1;
                rdata  <= r_ok ? rd_value : 32'h0;
                rresp  <= r_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtc_enable    <= 1'b0;
            match0        <= 32'h0;
            match1        <= 32'h0;
            subsec_match0 <= 16'h0;
            trim          <= `TRIM_RESET;
            wake_cfg      <= 3'h0;
            irq_enable    <= 4'h0;
        end else begin
            if (w_ctl) begin
                rtc_enable <= ctl_merged[`CTL_RTC_ENABLE];
            end
            if (w_m0) begin
                match0 <= merge(match0, w_data_q, w_strb_q);
            end
            if (w_m1) begin
                match1 <= merge(match1, w_data_q, w_strb_q);
            end
            if (w_ssm0) begin
                subsec_match0 <= 16'(merge({16'h0, subsec_match0}, w_data_q, w_strb_q));
            end
            if (w_trim) begin
                trim <= 16'(merge({16'h0, trim}, w_data_q, w_strb_q));
            end
            if (w_wake) begin
                wake_cfg <= 3'(merge({29'h0, wake_cfg}, w_data_q, w_strb_q));
            end
            if (w_irqen) begin
                irq_enable <= 4'(merge({28'h0, irq_enable}, w_data_q, w_strb_q));
            end
        end
    end

    // Loading seconds restarts the sub-second so a full second follows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seconds <= 32'h0;
            subsec  <= 16'h0;
        end else if (w_sec) begin
            seconds <= merge(seconds, w_data_q, w_strb_q);
            subsec  <= 16'h0;
        end else if (sub_roll) begin
            seconds <= seconds + 32'h1;
            subsec  <= 16'h0;
        end else if (step) begin
            subsec  <= subsec + 16'h1;
        end
    end

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_status  <= 4'h0;
            match0_prev <= 1'b0;
            match1_prev <= 1'b0;
        end else begin
            raw_status  <= (raw_status & ~clear_mask) | events;
            match0_prev <= match0_eq;
            match1_prev <= match1_eq;
        end
    end

    // Pins settle once the second and third stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1    <= 2'b01;
            pin_s2    <= 2'b01;
            pin_s3    <= 2'b01;
            pin_level <= 2'b01;
            pin_prev  <= 2'b01;
        end else begin
            pin_s1   <= {low_supply, wake_pin_n};
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_prev <= pin_level;
            for (int i = 0; i < 2; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_level[i] <= pin_s3[i];
                end
            end
        end
    end

    always_comb begin
        next_power_state = power_state;
        case (power_state)
            POWER_RUN: begin
                if (hib_request) begin
                    next_power_state = POWER_HIB;
                end
            end
            POWER_HIB: begin
                if (wake_req) begin
                    next_power_state = POWER_RUN;
                end
            end
            default: next_power_state = POWER_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_state      <= POWER_RUN;
            regulator_enable <= 1'b1;
        end else begin
            power_state      <= next_power_state;
            regulator_enable <= (next_power_state == POWER_RUN);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_to(logic sel);
        sel ##1 bvalid;
    endsequence

    sub_wrap_a: assert property (sub_roll && !w_sec |=> subsec == 16'h0 &&
        seconds == $past(seconds) + 32'h1)
        else $error("sub-second wrap did not advance seconds");
    trim_term_a: assert property (step && !trim_second && subsec == 16'h7fff && !w_sec
        |=> subsec == 16'h0)
        else $error("nominal second length wrong");
    trim_apply_a: assert property (step && trim_second && subsec < trim && !w_sec
        |=> subsec == $past(subsec) + 16'h1)
        else $error("trim second cut short");
    disabled_hold_a: assert property (!rtc_enable && !w_sec |=> $stable(subsec) &&
        $stable(seconds))
        else $error("counters moved while disabled");
    seconds_load_a: assert property (write_to(w_sec && w_strb_q == 4'hf) |->
        seconds == $past(w_data_q) && subsec == 16'h0)
        else $error("seconds write not loaded");
    match0_flag_a: assert property (match0_evt |=> raw_status[`ST_MATCH0])
        else $error("match 0 flag not set");
    flag_sticky_a: assert property (raw_status[`ST_MATCH1] && !clear_mask[`ST_MATCH1]
        |=> raw_status[`ST_MATCH1])
        else $error("match 1 flag dropped without clear");
    masked_view_a: assert property (rvalid && rresp == `RESP_OKAY &&
        $past(r_idx) == `REG_MASKED_STATUS && $rose(rvalid) |->
        rdata[3:0] == ($past(raw_status) & $past(irq_enable)))
        else $error("masked status read wrong");
    wake_restore_a: assert property (power_state == POWER_HIB && wake_req
        |=> regulator_enable ##1 regulator_enable [*2])
        else $error("regulator not restored on wake");
    hib_entry_a: assert property (power_state == POWER_RUN && hib_request
        |=> !regulator_enable)
        else $error("hibernation request ignored");
endmodule
`default_nettype wire

// ### rtl/tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// ### rtl/time_source_tick.sv
`timescale 1ns/100ps
`default_nettype none
module time_source_tick (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic time_src,
    tick_if.src       tk
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic level;

    // One sub-second step per settled rising edge of the source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1   <= 1'b0;
            sync2   <= 1'b0;
            sync3   <= 1'b0;
            level   <= 1'b0;
            tk.tick <= 1'b0;
        end else begin
            sync1   <= time_src;
            sync2   <= sync1;
            sync3   <= sync2;
            if (sync2 == sync3) begin
                level <= sync3;
            end
            tk.tick <= (sync2 == sync3) & sync3 & ~level;
        end
    end

    tick_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tk.tick |=> !tk.tick)
        else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire
